//--- hw/lesd_defs.vh
// register map, field positions, reset values and dft constants of the line state detector
`ifndef LESD_DEFS_VH
`define LESD_DEFS_VH

// register byte offsets
`define LESD_CTRL_OFS 4'h0
`define LESD_VTHR_OFS 4'h4
`define LESD_ITHR_OFS 4'h8
`define LESD_STAT_OFS 4'hc

// control register fields
`define LESD_CTRL_EN_BIT 0
`define LESD_CTRL_RST 1'h0

// threshold registers: percent of rated value, 7 bits
`define LESD_PCT_W 7
`define LESD_VTHR_RST 7'h3c
`define LESD_VTHR_MIN 7'h0a
`define LESD_VTHR_MAX 7'h64
`define LESD_ITHR_RST 7'h0a
`define LESD_ITHR_MIN 7'h02
`define LESD_ITHR_MAX 7'h64

// status register fields
`define LESD_STAT_VFLAG_LSB 0
`define LESD_STAT_IFLAG_LSB 3
`define LESD_STAT_DEAD_BIT 6
`define LESD_STAT_LIVE_BIT 7

// one-cycle dft: samples per fundamental period and coefficient scale
`define LESD_DFT_N 16
`define LESD_DFT_IDX_W 4
`define LESD_COEF_W 8
// gain used by the limit: N/2 samples times 128, one above the coefficient peak 127
`define LESD_DFT_GAIN 11'h400
`define LESD_PCT_FULL 7'h64

`endif

//--- hw/lesd_dead_line_detector.v
// three-phase dead/live line detector with apb settings and per-channel one-cycle dft
// How it works
// - each of the six voltage and current channels gets its own fundamental from a window of sixteen samples that restarts every period.
// - each phase has a voltage start flag that is high while its fundamental voltage is above the voltage limit.
// - each phase has a current start flag that is high while its fundamental current is above the current limit.
// - the dead output is high only when all three voltages and all three currents are below their limits.
// - the live output is high only when all three voltages are above the voltage limit, whatever the currents.
// - an enable setting, off after reset, keeps both line state outputs low while off.
// - the voltage limit is a percent from 10 to 100 in steps of 1, starting at 60.
// - the current limit is a percent from 2 to 100 in steps of 1, starting at 10.
// - an external block input keeps the function disabled and the line state outputs low while high.
// - the decision combines the six start flags with the block input and the enable setting.
`timescale 1ns/1ps
`default_nettype none
`include "lesd_defs.vh"

module lesd_dead_line_detector #(
  parameter SAMPLE_W = 16,
  parameter RATED_V_PEAK = 16'h2000,
  parameter RATED_I_PEAK = 16'h2000
) (
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [3:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // sampled channels, taken when sample_valid is high
  input wire sample_valid,
  input wire signed [SAMPLE_W-1:0] phase_a_voltage,
  input wire signed [SAMPLE_W-1:0] phase_b_voltage,
  input wire signed [SAMPLE_W-1:0] phase_c_voltage,
  input wire signed [SAMPLE_W-1:0] phase_a_current,
  input wire signed [SAMPLE_W-1:0] phase_b_current,
  input wire signed [SAMPLE_W-1:0] phase_c_current,
  // external block
  input wire function_block_input,
  // per-phase flags and line state
  output reg phase_a_voltage_start_flag,
  output reg phase_b_voltage_start_flag,
  output reg phase_c_voltage_start_flag,
  output reg phase_a_current_start_flag,
  output reg phase_b_current_start_flag,
  output reg phase_c_current_start_flag,
  output reg line_dead_output,
  output reg line_live_output
);

  localparam PW = `LESD_PCT_W;
  localparam CW = `LESD_COEF_W;
  localparam IW = `LESD_DFT_IDX_W;
  localparam ACC = SAMPLE_W + CW + IW + 1;
  localparam MW = 2 * ACC + 1;
  localparam TP = SAMPLE_W + PW + 11;
  localparam TW = 2 * TP;
  localparam [SAMPLE_W-1:0] RV = RATED_V_PEAK;
  localparam [SAMPLE_W-1:0] RI = RATED_I_PEAK;
  // window counts worked out at full width, then cut to the index width on purpose
  localparam [31:0] DFT_LAST = `LESD_DFT_N - 1;
  localparam [31:0] DFT_QUARTER = `LESD_DFT_N / 4;
  localparam [IW-1:0] LAST_IDX = DFT_LAST[IW-1:0];
  localparam [IW-1:0] QUARTER = DFT_QUARTER[IW-1:0];

  // settings
  reg op_enable;
  reg [PW-1:0] vthr_pct;
  reg [PW-1:0] ithr_pct;

  // window state
  reg [IW-1:0] win_idx;
  reg win_done;
  reg [5:0] over_raw;
  // per-channel comparison, registered in one place so each flag bit has one driver
  wire [5:0] over_now;

  // cosine of 2*pi*k/16 scaled to 127, built from a quarter table
  // indices past the first quarter fold back onto the same five magnitudes, 127 down to 0,
  // and the sign is set by the quarter they fall in, negative in the second and third
  function signed [CW-1:0] cos_coef;
    input [IW-1:0] k;
    reg [2:0] q;
    reg signed [CW-1:0] t;
    begin
      q = 3'h0;
      if (k <= 4'h4) begin
        q = k[2:0];
      end else if (k <= 4'h8) begin
        q = 3'h0 - k[2:0];
      end else if (k <= 4'hc) begin
        q = k[2:0];
      end else begin
        q = 3'h0 - k[2:0];
      end
      case (q)
        3'h0: t = 8'sh7f;
        3'h1: t = 8'sh75;
        3'h2: t = 8'sh5a;
        3'h3: t = 8'sh31;
        default: t = 8'sh00;
      endcase
      if (k > 4'h4 && k < 4'hc) begin
        cos_coef = -t;
      end else begin
        cos_coef = t;
      end
    end
  endfunction

  // clamp a percent write into its legal range
  // the test runs on the full word so a large value can not wrap back into range
  function [PW-1:0] clamp_pct;
    input [31:0] d;
    input [PW-1:0] lo;
    input [PW-1:0] hi;
    begin
      if (d < {25'h0, lo}) begin
        clamp_pct = lo;
      end else if (d > {25'h0, hi}) begin
        clamp_pct = hi;
      end else begin
        clamp_pct = d[PW-1:0];
      end
    end
  endfunction

  // coefficients for the current index; the sine term is the cosine a quarter period back
  // channel order on the bus: voltages a..c in the low words, currents a..c above them
  wire signed [CW-1:0] coef_re = cos_coef(win_idx);
  wire signed [CW-1:0] coef_im = cos_coef(win_idx - QUARTER);
  wire [6*SAMPLE_W-1:0] chan_bus = {phase_c_current, phase_b_current, phase_a_current,
                                    phase_c_voltage, phase_b_voltage, phase_a_voltage};

  // limit in dft units: rated peak * percent * gain / 100, then squared
  // the bin gain is 8 * 127 = 1016 while the limit uses 1024, so pick-up sits a little
  // under one percent above the setting; a power of two keeps the scaling a shift
  // comparing squares avoids a square root per channel at the cost of wide multipliers
  wire [TP-1:0] vthr_prod = RV * vthr_pct * `LESD_DFT_GAIN;
  wire [TP-1:0] ithr_prod = RI * ithr_pct * `LESD_DFT_GAIN;
  wire [TP-1:0] vthr_amp = vthr_prod / `LESD_PCT_FULL;
  wire [TP-1:0] ithr_amp = ithr_prod / `LESD_PCT_FULL;
  wire [TW-1:0] vthr_sq = vthr_amp * vthr_amp;
  wire [TW-1:0] ithr_sq = ithr_amp * ithr_amp;

  // apb access decode
  // only the four mapped offsets answer without an error
  wire apb_access = psel & penable;
  wire apb_known = (paddr == `LESD_CTRL_OFS) | (paddr == `LESD_VTHR_OFS) |
                   (paddr == `LESD_ITHR_OFS) | (paddr == `LESD_STAT_OFS);
  wire apb_commit = apb_access & pready;
  wire active = op_enable & ~function_block_input;

  // status word packed at the field positions of the register map
  wire [7:0] status_bits;
  assign status_bits[`LESD_STAT_VFLAG_LSB +: 3] = {phase_c_voltage_start_flag, phase_b_voltage_start_flag,
                                                  phase_a_voltage_start_flag};
  assign status_bits[`LESD_STAT_IFLAG_LSB +: 3] = {phase_c_current_start_flag, phase_b_current_start_flag,
                                                  phase_a_current_start_flag};
  assign status_bits[`LESD_STAT_DEAD_BIT] = line_dead_output;
  assign status_bits[`LESD_STAT_LIVE_BIT] = line_live_output;

  // window sample index, wraps every fundamental period
  // the bin is exact only with 16 samples per period; a drifting line frequency leaks
  // a little and reads slightly low, which users should allow for in the limits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_idx <= {IW{1'b0}};
      win_done <= 1'b0;
    end else if (clk_en) begin
      win_done <= sample_valid && (win_idx == LAST_IDX);
      if (sample_valid) begin
        win_idx <= win_idx + {{(IW-1){1'b0}}, 1'b1};
      end
    end
  end

  // one dft bin per channel, voltages on 0..2 and currents on 3..5
  // products are sign-extended so sixteen terms fit the accumulator without overflow
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : chan
      wire signed [SAMPLE_W-1:0] x = chan_bus[g*SAMPLE_W +: SAMPLE_W];
      wire signed [SAMPLE_W+CW-1:0] p_re = x * coef_re;
      wire signed [SAMPLE_W+CW-1:0] p_im = x * coef_im;
      wire signed [ACC-1:0] p_re_x = {{(IW+1){p_re[SAMPLE_W+CW-1]}}, p_re};
      wire signed [ACC-1:0] p_im_x = {{(IW+1){p_im[SAMPLE_W+CW-1]}}, p_im};
      reg signed [ACC-1:0] acc_re;
      reg signed [ACC-1:0] acc_im;
      reg signed [ACC-1:0] fund_re;
      reg signed [ACC-1:0] fund_im;
      wire signed [MW-1:0] mag_sq = fund_re * fund_re + fund_im * fund_im;
      wire [MW-1:0] mag_u = mag_sq;
      wire [TW-1:0] lim = (g < 3) ? vthr_sq : ithr_sq;
      // accumulate over one period, latch the finished sum as the fundamental
      // the sample that closes the window goes straight into the latched sum
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_re <= {ACC{1'b0}};
          acc_im <= {ACC{1'b0}};
          fund_re <= {ACC{1'b0}};
          fund_im <= {ACC{1'b0}};
        end else if (clk_en && sample_valid) begin
          if (win_idx == LAST_IDX) begin
            fund_re <= acc_re + p_re_x;
            fund_im <= acc_im + p_im_x;
            acc_re <= {ACC{1'b0}};
            acc_im <= {ACC{1'b0}};
          end else begin
            acc_re <= acc_re + p_re_x;
            acc_im <= acc_im + p_im_x;
          end
        end
      end
      // squared magnitude against squared limit; strict, so a value on the limit is not above it
      assign over_now[g] = {{(TW-MW){1'b0}}, mag_u} > lim;
    end
  endgenerate

  // raw flags change only when a window has just finished, never in between
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_raw <= 6'h00;
    end else if (clk_en && win_done) begin
      over_raw <= over_now;
    end
  end

  // decision: flags and line state follow the raw flags, gated by enable and block
  // gating is registered, so enable and block act one cycle later; the raw flags keep
  // running underneath, so a release shows the current window at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_a_voltage_start_flag <= 1'b0;
      phase_b_voltage_start_flag <= 1'b0;
      phase_c_voltage_start_flag <= 1'b0;
      phase_a_current_start_flag <= 1'b0;
      phase_b_current_start_flag <= 1'b0;
      phase_c_current_start_flag <= 1'b0;
      line_dead_output <= 1'b0;
      line_live_output <= 1'b0;
    end else if (clk_en) begin
      phase_a_voltage_start_flag <= active & over_raw[0];
      phase_b_voltage_start_flag <= active & over_raw[1];
      phase_c_voltage_start_flag <= active & over_raw[2];
      phase_a_current_start_flag <= active & over_raw[3];
      phase_b_current_start_flag <= active & over_raw[4];
      phase_c_current_start_flag <= active & over_raw[5];
      // mixed voltages match neither state, so both stay low
      line_dead_output <= active & ~(|over_raw);
      line_live_output <= active & (&over_raw[2:0]);
    end
  end

  // apb: one wait state, pready rises in the second access cycle
  // a low clock enable also stalls the answer, so a master must not time out on it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= apb_access & ~pready;
      pslverr <= apb_access & ~pready & ~apb_known;
      // read data falls back to zero outside the answer so a stale word is never seen
      prdata <= 32'h0;
      if (apb_access && !pready && !pwrite) begin
        case (paddr)
          `LESD_CTRL_OFS: prdata <= {31'h0, op_enable};
          `LESD_VTHR_OFS: prdata <= {25'h0, vthr_pct};
          `LESD_ITHR_OFS: prdata <= {25'h0, ithr_pct};
          `LESD_STAT_OFS: prdata <= {24'h0, status_bits};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // settings take a write at the edge that completes the transfer
  // a write to the status offset falls to the default branch and changes nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // enable off and both limits at their defaults after reset
      op_enable <= `LESD_CTRL_RST;
      vthr_pct <= `LESD_VTHR_RST;
      ithr_pct <= `LESD_ITHR_RST;
    end else if (clk_en && apb_commit && pwrite) begin
      case (paddr)
        `LESD_CTRL_OFS: op_enable <= pwdata[`LESD_CTRL_EN_BIT];
        // out of range writes clamp so the limit never leaves its legal span
        `LESD_VTHR_OFS: vthr_pct <= clamp_pct(pwdata, `LESD_VTHR_MIN, `LESD_VTHR_MAX);
        `LESD_ITHR_OFS: ithr_pct <= clamp_pct(pwdata, `LESD_ITHR_MIN, `LESD_ITHR_MAX);
        default: op_enable <= op_enable;
      endcase
    end
  end

endmodule // lesd_dead_line_detector

`default_nettype wire

//--- dv/lesd_dead_line_detector_assertions.sv
// port-level checks of the line state detector
`timescale 1ns/1ps
`default_nettype none
module lesd_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // block input, flags, line state
  input wire logic function_block_input,
  input wire logic phase_a_voltage_start_flag,
  input wire logic phase_b_voltage_start_flag,
  input wire logic phase_c_voltage_start_flag,
  input wire logic phase_a_current_start_flag,
  input wire logic phase_b_current_start_flag,
  input wire logic phase_c_current_start_flag,
  input wire logic line_dead_output,
  input wire logic line_live_output
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [2:0] vf = {phase_c_voltage_start_flag, phase_b_voltage_start_flag, phase_a_voltage_start_flag};
  wire [2:0] cf = {phase_c_current_start_flag, phase_b_current_start_flag, phase_a_current_start_flag};
  wire quiet = !line_dead_output && !line_live_output && vf == 3'h0 && cf == 3'h0;
  // apb steps: setup, then first access cycle
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && clk_en; endsequence
  apb_answer_a: assert property (setup_s ##1 access_s |=> pready) else $error("apb answer late");
  ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("pready held");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside answer");
  live_needs_v_a: assert property (line_live_output |-> &vf) else $error("live without voltages");
  dead_needs_low_a: assert property (line_dead_output |-> vf == 3'h0 && cf == 3'h0) else $error("dead with a flag");
  state_exclusive_a: assert property (!(line_dead_output && line_live_output)) else $error("dead and live");
  block_quiets_a: assert property (function_block_input && clk_en |=> quiet) else $error("block ignored");
  reset_clear_a: assert property ($rose(presetn) |-> quiet) else $error("outputs set after reset");
endmodule // lesd_checker
bind lesd_dead_line_detector lesd_checker i_lesd_checker (.pclk, .presetn, .clk_en, .psel, .penable,
  .prdata, .pready, .pslverr, .function_block_input, .phase_a_voltage_start_flag, .phase_b_voltage_start_flag,
  .phase_c_voltage_start_flag, .phase_a_current_start_flag, .phase_b_current_start_flag,
  .phase_c_current_start_flag, .line_dead_output, .line_live_output);
`default_nettype wire

//--- dv/lesd_front_end.sv
// acquisition front end model: sine samples of set peak on six channels
`timescale 1ns/1ps
`default_nettype none
module lesd_front_end (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // peaks: voltage a,b,c then current a,b,c; slow spaces samples four cycles apart
  input wire logic [95:0] amps,
  input wire logic slow,
  // sample stream
  output logic sample_valid,
  output logic [95:0] smp
);
  logic [3:0] k;
  logic [1:0] div;
  // sixteen samples per period; idle lines toggle so a stale value is never mistaken for data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k <= 4'h0;
      div <= 2'h0;
      sample_valid <= 1'b0;
      smp <= 96'h0;
    end else begin
      div <= div + 2'h1;
      sample_valid <= !slow || div == 2'h3;
      if (!slow || div == 2'h3) begin
        k <= k + 4'h1;
        for (int c = 0; c < 6; c++)
          smp[c*16 +: 16] <= 16'($rtoi($itor(amps[c*16 +: 16]) * $sin(6.2831853 * k / 16.0)));
      end else begin
        smp <= ~smp;
      end
    end
  end
endmodule // lesd_front_end
`default_nettype wire

//--- dv/line_energization_state_detector_test.sv
// self-checking bench of the line state detector
`timescale 1ns/1ps
`default_nettype none
module line_energization_state_detector_test;
  localparam int SETTLE = 3 * 16 * 4 + 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, slow, blk, e, ce;
  logic [3:0] paddr;
  logic [31:0] pwdata, prdata, q, r, seed;
  logic [95:0] amps, smp;
  logic [5:0] above;
  logic [7:0] want;
  wire live, dead;
  wire [2:0] vf, cf;
  int fail_count, num_checks, vthr, ithr, en;
  lesd_dead_line_detector i_lesd_dead_line_detector (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .phase_a_voltage(smp[15:0]),
    .phase_b_voltage(smp[31:16]), .phase_c_voltage(smp[47:32]), .phase_a_current(smp[63:48]),
    .phase_b_current(smp[79:64]), .phase_c_current(smp[95:80]), .function_block_input(blk),
    .phase_a_voltage_start_flag(vf[0]), .phase_b_voltage_start_flag(vf[1]), .phase_c_voltage_start_flag(vf[2]),
    .phase_a_current_start_flag(cf[0]), .phase_b_current_start_flag(cf[1]), .phase_c_current_start_flag(cf[2]),
    .line_dead_output(dead), .line_live_output(live));
  lesd_front_end i_lesd_front_end (.pclk(pclk), .presetn(presetn), .amps(amps), .slow(slow),
    .sample_valid(sample_valid), .smp(smp));
  always #5 pclk = ~pclk;
  // apb transfer; an idle cycle follows so no signal is assigned twice at one edge
  task apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the answer however long it takes; only the watchdog ends a hang
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // peak well clear of the limit on either side; limit is percent of the rated peak 8192
  function automatic logic [15:0] amp_for(int thr, logic up);
    return up ? 16'(8192 * (thr + 15) / 100) : 16'(8192 * thr / 200);
  endfunction
  // expected status byte: live, dead, current flags c..a, voltage flags c..a
  function automatic logic [7:0] exp_status(int en, logic blk, logic [5:0] ab);
    logic g;
    g = en != 0 && !blk;
    return {g && &ab[2:0], g && ab == 6'h0, ab[5:3] & {3{g}}, ab[2:0] & {3{g}}};
  endfunction
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    amps = 0; slow = 0; blk = 0; seed = 32'h930dbccc; fail_count = 0; num_checks = 0;
    ce = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped address, clamping at both range ends
    apb(0, 4'h0, 0); check(q, 32'h0);
    apb(0, 4'h4, 0); check(q, 32'h3c);
    apb(0, 4'h8, 0); check(q, 32'h0a);
    apb(0, 4'h2, 0); check(e, 1); check(q, 0);
    apb(1, 4'h4, 32'h09); apb(0, 4'h4, 0); check(q, 32'h0a);
    apb(1, 4'h8, 32'h65); apb(0, 4'h8, 0); check(q, 32'h64);
    $display("test reset_and_limits done");
    // corners first: all low, all high at limit ends, disabled, blocked; then random
    for (int n = 0; n < 12; n++) begin
      r = $random(seed);
      vthr = n == 0 ? 10 : n == 1 ? 100 : 10 + r[15:0] % 91;
      ithr = n == 0 ? 100 : n == 1 ? 2 : 2 + r[31:16] % 99;
      en = n != 2;
      above = n == 0 ? 6'h0 : n < 4 ? 6'h3f : r[13:8];
      apb(1, 4'h4, vthr); apb(0, 4'h4, 0); check(q, vthr);
      apb(1, 4'h8, ithr); apb(0, 4'h8, 0); check(q, ithr);
      apb(1, 4'h0, en);
      blk <= n == 3 || (n > 3 && r[1:0] == 2'h3);
      slow <= r[2];
      for (int c = 0; c < 6; c++) amps[c*16 +: 16] <= amp_for(c < 3 ? vthr : ithr, above[c]);
      repeat (SETTLE) @(posedge pclk);
      want = exp_status(en, blk, above);
      check({live, dead, cf, vf}, want);
      apb(0, 4'hc, 0); check(q, {24'h0, want});
      $display("test case %0d done", n);
    end
    // freeze: outputs hold while the clock enable is low, although the block input flips
    ce <= 1'b0;
    blk <= ~blk;
    repeat (40) @(posedge pclk);
    check({live, dead, cf, vf}, want);
    // recover with every channel above the limit, then reset in mid-run
    ce <= 1'b1;
    blk <= 1'b0;
    above = 6'h3f;
    for (int c = 0; c < 6; c++) amps[c*16 +: 16] <= amp_for(c < 3 ? vthr : ithr, 1'b1);
    repeat (SETTLE) @(posedge pclk);
    check({live, dead, cf, vf}, exp_status(en, 1'b0, above));
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check({live, dead, cf, vf}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 4'h0, 0); check(q, 32'h0);
    apb(0, 4'h4, 0); check(q, 32'h3c);
    apb(0, 4'h8, 0); check(q, 32'h0a);
    $display("test freeze and mid reset done");
    end_of_test;
  end
endmodule // line_energization_state_detector_test
`default_nettype wire
